// ### sim/mict_mem.sv
// program and data memory model facing the core
`timescale 1ns/1ns
`default_nettype none
module mict_mem (
    input  wire logic        clk_i,
    input  wire logic [11:0] pmem_addr_i,
    output logic      [15:0] pmem_data_o,
    input  wire logic [9:0]  dmem_addr_i,
    input  wire logic [7:0]  dmem_wdata_i,
    input  wire logic        dmem_we_i,
    output logic      [7:0]  dmem_rdata_o
);
    // ************************************************************
    // arrays
    // ************************************************************
    logic [15:0] pmem [0:4095];
    logic [7:0]  dmem [0:255];
    assign pmem_data_o = pmem[pmem_addr_i];
    // marker outside sector 0
    assign dmem_rdata_o = (dmem_addr_i[9:8] == 2'h0) ? dmem[dmem_addr_i[7:0]] : 8'ha5;
    always @(posedge clk_i) begin
        if (dmem_we_i) begin
            dmem[dmem_addr_i[7:0]] <= dmem_wdata_i;
        end
    end
endmodule // mict_mem
`default_nettype wire

// ### sim/mict_monitor.sv
// assertion checker for the core
`timescale 1ns/1ns
`default_nettype none
module mict_monitor (
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    input wire logic        wake_i,
    input wire logic [15:0] pmem_data_i,
    input wire logic [7:0]  dmem_rdata_i,
    input wire logic [11:0] pmem_addr_o,
    input wire logic [9:0]  dmem_addr_o,
    input wire logic [7:0]  dmem_wdata_o,
    input wire logic        dmem_we_o,
    input wire logic [7:0]  acc_o,
    input wire logic [7:0]  tblh_o,
    input wire logic        zero_o,
    input wire logic        carry_o,
    input wire logic        global_interrupt_enable_o,
    input wire logic        halt_o,
    input wire logic        icyc_end_o
);
    // ************************************************************
    // checks
    // ************************************************************
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    property p_cyc; icyc_end_o |=> !icyc_end_o [*3] ##1 icyc_end_o; endproperty
    a_cyc: assert property (p_cyc) else $error("bad cycle");
    property p_pc; !icyc_end_o |=> $stable(pmem_addr_o); endproperty
    a_pc: assert property (p_pc) else $error("fetch moved");
    property p_acc; !icyc_end_o |=> $stable({acc_o, zero_o, carry_o}); endproperty
    a_acc: assert property (p_acc) else $error("result moved");
    property p_sec; dmem_addr_o[9:8] == 2'h0; endproperty
    a_sec: assert property (p_sec) else $error("sector not 0");
    property p_we; dmem_we_o |-> $past(icyc_end_o) ##1 !dmem_we_o; endproperty
    a_we: assert property (p_we) else $error("bad strobe");
    property p_pcl; dmem_we_o |-> dmem_addr_o != 10'h002; endproperty
    a_pcl: assert property (p_pcl) else $error("low pc written");
    property p_gie; 1'b1 |-> !$fell(global_interrupt_enable_o); endproperty
    a_gie: assert property (p_gie) else $error("enable fell");
    property p_hwr; halt_o |-> !dmem_we_o; endproperty
    a_hwr: assert property (p_hwr) else $error("halt write");
    property p_hst; halt_o && $past(halt_o) |-> $stable(pmem_addr_o); endproperty
    a_hst: assert property (p_hst) else $error("halt fetch moved");
    property p_hup; $rose(halt_o) |-> $past(icyc_end_o); endproperty
    a_hup: assert property (p_hup) else $error("halt mid cycle");
endmodule // mict_monitor
bind mict_core mict_monitor u_mict_monitor (.clk_i, .rst_n_i, .wake_i, .pmem_data_i,
    .dmem_rdata_i, .pmem_addr_o, .dmem_addr_o, .dmem_wdata_o, .dmem_we_o, .acc_o, .tblh_o,
    .zero_o, .carry_o, .global_interrupt_enable_o, .halt_o, .icyc_end_o);
`default_nettype wire

// ### sim/tb_mcu_instruction_timing_and_semantics.sv
// self-checking bench for the core
`timescale 1ns/1ns
`default_nettype none
module tb_mcu_instruction_timing_and_semantics;
    localparam logic [15:0] JUNK = 16'h37ee;
    logic        clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        wake_i = 1'b0;
    logic [15:0] pmem_data_i;
    logic [11:0] pmem_addr_o;
    logic [9:0]  dmem_addr_o;
    logic [7:0]  dmem_rdata_i, dmem_wdata_o, acc_o, tblh_o;
    logic        dmem_we_o, zero_o, carry_o, gie_o, halt_o, icyc_end_o;
    int          num_errors = 0, compares = 0;
    int          p, ma, mz, mc, mg, mt, tk, i, k, n, pa;
    int          md [256];
    int          stk [$], q [$];
    always #50 clk_i = ~clk_i;
    mict_core u_mict_core (.clk_i, .rst_n_i, .wake_i, .pmem_data_i, .dmem_rdata_i,
        .pmem_addr_o, .dmem_addr_o, .dmem_wdata_o, .dmem_we_o, .acc_o, .tblh_o, .zero_o,
        .carry_o, .global_interrupt_enable_o(gie_o), .halt_o, .icyc_end_o);
    mict_mem u_mict_mem (.clk_i, .pmem_addr_i(pmem_addr_o), .pmem_data_o(pmem_data_i),
        .dmem_addr_i(dmem_addr_o), .dmem_wdata_i(dmem_wdata_o), .dmem_we_i(dmem_we_o),
        .dmem_rdata_o(dmem_rdata_i));
    // ************************************************************
    // reference model
    // ************************************************************
    task automatic al(int f, int b, output int r);
        case (f)
            0: r = ma + b;
            1: r = ma + b + mc;
            2: r = ma - b;
            3: r = ma - b - mc;
            4: r = ma & b;
            5: r = ma | b;
            6: r = ma ^ b;
            default: r = b;
        endcase
        if (f < 4) mc = (r > 255 || r < 0);
        r = r & 255;
        if (f < 7) mz = (r == 0);
    endtask
    task automatic un(int f, int v, output int r);
        case (f)
            0: r = ~v;
            1: r = v + 1;
            2: r = v - 1;
            3: r = (v >> 1) | (v << 7);
            4: r = (v << 1) | (v >> 7);
            5: r = (v >> 1) | (mc << 7);
            6: r = (v << 1) | mc;
            default: r = (v >> 4) | (v << 4);
        endcase
        if (f == 5) mc = v & 1;
        if (f == 6) mc = (v >> 7) & 1;
        r = r & 255;
        if (f < 3) mz = (r == 0);
    endtask
    task automatic ex(logic [15:0] w);
        int op, f, m, v, r, c;
        op = w[15:12];
        f = w[10:8];
        m = w[7:0];
        c = 1;
        tk = 0;
        u_mict_mem.pmem[p] = w;
        p++;
        v = (op == 3) ? m : md[m];
        case (op)
            0: if (f == 2 || f == 3) begin
                mg = mg | (f == 3);
                u_mict_mem.pmem[p] = JUNK;
                p = stk.pop_back();
                c = 2;
            end
            1, 3: al(f, v, ma);
            4: un(f, v, ma);
            2, 5: begin
                if (op == 2) al(f, v, r);
                else un(f, v, r);
                if (op == 2 && f == 7) r = ma;
                if (m == 2) begin
                    u_mict_mem.pmem[p] = JUNK;
                    p = (p & 'hf00) | r;
                    c = 2;
                end else md[m] = r;
            end
            6: md[m] = md[m] & ~(1 << f);
            7: md[m] = md[m] | (1 << f);
            8, 9: tk = ((v >> f) & 1) == (op == 9);
            10: begin
                r = ((f & 3) == 2) ? v + 1 : ((f & 3) == 3) ? v - 1 : v;
                r = r & 255;
                tk = ((f & 3) == 1) ? (r != 0) : (r == 0);
                if (f > 3) ma = r;
                else if ((f & 3) > 1) md[m] = r;
            end
            11: begin
                r = u_mict_mem.pmem[{w[11:8], 8'(ma)}];
                md[m] = r & 255;
                mt = r >> 8;
                c = 2;
            end
            12, 13: begin
                if (op == 13) stk.push_back(p);
                u_mict_mem.pmem[p] = JUNK;
                p = w[11:0];
                c = 2;
            end
        endcase
        if (tk) c = 2;
        q = {q, c, ma, mz, mc, mg, mt};
    endtask
    task automatic sk(logic [15:0] w);
        ex(w);
        if (tk) begin
            u_mict_mem.pmem[p] = JUNK;
            p++;
        end else ex(16'h375a);
    endtask
    // ************************************************************
    // checks
    // ************************************************************
    task automatic chk(string nm, int e, logic [7:0] s);
        compares++;
        if (s !== e[7:0]) begin
            num_errors++;
            $display("BAD %s exp %0h got %0h", nm, e[7:0], s);
        end
    endtask
    task automatic cyc(int c);
        repeat (c) @(posedge clk_i iff icyc_end_o === 1'b1);
        #10;
    endtask
    task conclude;
        if (num_errors == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // about forty times the run length
    initial begin
        #3_000_000;
        num_errors++;
        conclude;
    end
    initial begin
        void'($urandom(32'h62fc));
        for (i = 0; i < 4096; i++) u_mict_mem.pmem[i] = 16'h0000;
        for (i = 0; i < 256; i++) begin
            md[i] = $urandom % 256;
            u_mict_mem.dmem[i] = md[i];
        end
        for (i = 0; i < 60; i++) begin
            k = 1 + $urandom % 7;
            ex({k[3:0], 1'b0, 3'($urandom), (k == 3) ? 8'($urandom) : 8'h10 + 8'($urandom % 16)});
        end
        ex(16'hc100);
        ex(16'h3740);
        ex(16'h2702);
        ex(16'hd300);
        ex(16'h0200);
        ex(16'hd310);
        ex(16'h0300);
        for (k = 0; k < 12; k++) begin
            ex({8'h37, (k % 3 == 2) ? 8'hff : 8'(k % 3)});
            ex(16'h2735);
            sk({4'ha, 1'($urandom), 2'(k / 3), 8'h35});
        end
        for (k = 0; k < 8; k++) begin
            ex({8'h37, 8'($urandom)});
            ex(16'h2733);
            sk({4'h8 + 4'($urandom % 2), 1'b0, k[2:0], 8'h33});
            ex({4'h6 + 4'($urandom % 2), 1'b0, k[2:0], 8'h34});
            ex(16'h1734);
        end
        u_mict_mem.pmem[12'h755] = 16'($urandom);
        ex(16'h3755);
        ex(16'hb736);
        ex(16'h1736);
        ex(16'h0100);
        u_mict_mem.pmem[p] = 16'h3777;
        repeat (8) @(posedge clk_i);
        #10 rst_n_i = 1'b1;
        while (q.size() > 0) begin
            n = q.pop_front();
            if (n > 1) begin
                cyc(n - 1);
                chk("acc_early", q[0], acc_o);
            end
            cyc(1);
            pa = q.pop_front();
            chk("acc", pa, acc_o);
            chk("zero", q.pop_front(), zero_o);
            chk("carry", q.pop_front(), carry_o);
            chk("gie", q.pop_front(), gie_o);
            chk("tblh", q.pop_front(), tblh_o);
        end
        repeat (12) @(posedge clk_i);
        #10;
        chk("halt", 1, halt_o);
        wake_i = 1'b1;
        for (k = 0; k < 40 && halt_o !== 1'b0; k++) begin
            @(posedge clk_i);
            #10;
        end
        wake_i = 1'b0;
        cyc(2);
        chk("acc_wake", 8'h77, acc_o);
        for (i = 16; i < 64; i++) chk("dmem", md[i], u_mict_mem.dmem[i]);
        conclude;
    end
endmodule // tb_mcu_instruction_timing_and_semantics
`default_nettype wire

// ### src/mict_core.v
// instruction sequencing and execution core
// Behaviour
// - one instruction cycle is four system clocks
// - ordinary: one cycle; jump, call, return, table read: two
// - writing the program counter low byte jumps and costs one extra cycle
// - conditional skip takes one cycle without skip, two when skipping
// - skips test a byte or bit, then run or bypass next
// - call saves return point; return resumes after the call
// - unconditional jump loads target without saving any return address
// - logic and complement set zero flag exactly on zero result
// - logic operands pass through accumulator
// - rotates move the operand exactly one bit left or right
// - rotate through carry: out bit to carry, old carry in
// - add sets carry above 255; subtract sets borrow below zero
// - increment, decrement change by one, to memory or accumulator
// - moves: register and accumulator both ways, immediate to accumulator
// - bit set and clear do read-modify-write, other bits unchanged
// - bit index 0 to 7 selects one bit of the addressed byte
// - table read copies a program memory word: low byte to data memory, high byte to tblh
// - a power-down instruction puts the core in its low power state
// - direct data addressing reaches only data memory sector 0
// - interrupt return sets global enable; plain return does not
`timescale 1ns/1ns
`default_nettype none
`include "mict_regs.vh"

module mict_core (
    input  wire        clk_i,
    input  wire        rst_n_i,
    input  wire        wake_i,
    input  wire [15:0] pmem_data_i,
    input  wire [7:0]  dmem_rdata_i,
    output wire [11:0] pmem_addr_o,
    output wire [9:0]  dmem_addr_o,
    output wire [7:0]  dmem_wdata_o,
    output wire        dmem_we_o,
    output wire [7:0]  acc_o,
    output wire [7:0]  tblh_o,
    output wire        zero_o,
    output wire        carry_o,
    output wire        global_interrupt_enable_o,
    output wire        halt_o,
    output wire        icyc_end_o
);

    // ************************************************************
    // sequencer states
    // ************************************************************
    localparam [1:0] ST_RUN   = 2'h0;
    localparam [1:0] ST_FLUSH = 2'h1;
    localparam [1:0] ST_TABLE = 2'h2;
    localparam [1:0] ST_HALT  = 2'h3;

    // ************************************************************
    // functions
    // ************************************************************
    // bit 8 is carry for add, borrow for subtract
    function [8:0] mict_alu;
        input [2:0] f;
        input [7:0] a;
        input [7:0] b;
        input       ci;
        begin
            case (f)
                `MICT_ALU_ADD: mict_alu = {1'b0, a} + {1'b0, b};
                `MICT_ALU_ADC: mict_alu = {1'b0, a} + {1'b0, b} + {8'h00, ci};
                `MICT_ALU_SUB: mict_alu = {1'b0, a} - {1'b0, b};
                `MICT_ALU_SBC: mict_alu = {1'b0, a} - {1'b0, b} - {8'h00, ci};
                `MICT_ALU_AND: mict_alu = {1'b0, a & b};
                `MICT_ALU_OR:  mict_alu = {1'b0, a | b};
                `MICT_ALU_XOR: mict_alu = {1'b0, a ^ b};
                default:       mict_alu = {1'b0, b};
            endcase
        end
    endfunction

    // bit 8 is the carry after the operation
    function [8:0] mict_unary;
        input [2:0] f;
        input [7:0] v;
        input       ci;
        begin
            case (f)
                `MICT_UN_CPL:  mict_unary = {ci, ~v};
                `MICT_UN_INC:  mict_unary = {ci, v + 8'h01};
                `MICT_UN_DEC:  mict_unary = {ci, v - 8'h01};
                `MICT_UN_RR:   mict_unary = {ci, v[0], v[7:1]};
                `MICT_UN_RL:   mict_unary = {ci, v[6:0], v[7]};
                `MICT_UN_RRC:  mict_unary = {v[0], ci, v[7:1]};
                `MICT_UN_RLC:  mict_unary = {v[7], v[6:0], ci};
                default:       mict_unary = {ci, v[3:0], v[7:4]};
            endcase
        end
    endfunction

    function [7:0] mict_bit_mask;
        input [2:0] idx;
        begin
            mict_bit_mask = 8'h01 << idx;
        end
    endfunction

    // ************************************************************
    // state
    // ************************************************************
    reg [1:0]  phase_r;
    reg [1:0]  state_r;
    reg [11:0] pc_r;
    reg [11:0] pmem_addr_r;
    reg [15:0] ir_r;
    reg [7:0]  opnd_r;
    reg [7:0]  acc_r;
    reg        zero_r;
    reg        carry_r;
    reg        gie_r;
    reg [7:0]  tblh_r;
    reg [9:0]  dmem_addr_r;
    reg [7:0]  dmem_wdata_r;
    reg        dmem_we_r;
    reg [11:0] stack_r [0:7];
    reg [2:0]  sp_r;
    reg        wake_s1_r;
    reg        wake_s2_r;
    integer    i;

    // ************************************************************
    // execute decode
    // ************************************************************
    reg [7:0]  ex_res;
    reg        ex_wr_acc;
    reg        ex_wr_mem;
    reg        ex_z_upd;
    reg        ex_c_upd;
    reg        ex_c;
    reg        ex_skip;
    reg        ex_jump;
    reg [11:0] ex_target;
    reg        ex_push;
    reg        ex_pop;
    reg        ex_gie_set;
    reg        ex_halt;
    reg        ex_table;
    reg [8:0]  ex_wide;
    reg [7:0]  ex_mask;

    wire [2:0] sp_top = sp_r - `MICT_SP_STEP;
    wire       pcl_hit = ex_wr_mem && (ir_r[7:0] == `MICT_PCL_ADDR);
    wire [11:0] pc_inc = pc_r + `MICT_PC_STEP;

    always @* begin
        ex_res     = opnd_r;
        ex_wr_acc  = 1'b0;
        ex_wr_mem  = 1'b0;
        ex_z_upd   = 1'b0;
        ex_c_upd   = 1'b0;
        ex_c       = carry_r;
        ex_skip    = 1'b0;
        ex_jump    = 1'b0;
        ex_target  = pc_r;
        ex_push    = 1'b0;
        ex_pop     = 1'b0;
        ex_gie_set = 1'b0;
        ex_halt    = 1'b0;
        ex_table   = 1'b0;
        ex_wide    = 9'h000;
        ex_mask    = mict_bit_mask(ir_r[10:8]);
        case (ir_r[15:12])
            `MICT_OP_MISC: begin
                case (ir_r[11:8])
                    `MICT_MISC_HALT: ex_halt = 1'b1;
                    `MICT_MISC_RET, `MICT_MISC_INTERRUPT_RETURN, `MICT_MISC_RETA: begin
                        ex_pop     = 1'b1;
                        ex_jump    = 1'b1;
                        ex_target  = stack_r[sp_top];
                        ex_gie_set = (ir_r[11:8] == `MICT_MISC_INTERRUPT_RETURN);
                        ex_res     = ir_r[7:0];
                        ex_wr_acc  = (ir_r[11:8] == `MICT_MISC_RETA);
                    end
                    default: ex_halt = 1'b0;
                endcase
            end
            `MICT_OP_ALU_A, `MICT_OP_ALU_I: begin
                if (ir_r[15:12] == `MICT_OP_ALU_I) begin
                    ex_wide = mict_alu(ir_r[10:8], acc_r, ir_r[7:0], carry_r);
                end else begin
                    ex_wide = mict_alu(ir_r[10:8], acc_r, opnd_r, carry_r);
                end
                ex_res    = ex_wide[7:0];
                ex_wr_acc = 1'b1;
                ex_z_upd  = (ir_r[10:8] != `MICT_ALU_MOV);
                ex_c_upd  = (ir_r[10:8] < `MICT_ALU_AND);
                ex_c      = ex_wide[8];
            end
            `MICT_OP_ALU_M: begin
                ex_wide   = mict_alu(ir_r[10:8], acc_r, opnd_r, carry_r);
                ex_res    = (ir_r[10:8] == `MICT_ALU_MOV) ? acc_r : ex_wide[7:0];
                ex_wr_mem = 1'b1;
                ex_z_upd  = (ir_r[10:8] != `MICT_ALU_MOV);
                ex_c_upd  = (ir_r[10:8] < `MICT_ALU_AND);
                ex_c      = ex_wide[8];
            end
            `MICT_OP_UN_A, `MICT_OP_UN_M: begin
                ex_wide   = mict_unary(ir_r[10:8], opnd_r, carry_r);
                ex_res    = ex_wide[7:0];
                ex_wr_acc = (ir_r[15:12] == `MICT_OP_UN_A);
                ex_wr_mem = (ir_r[15:12] == `MICT_OP_UN_M);
                ex_z_upd  = (ir_r[10:8] <= `MICT_UN_DEC);
                ex_c_upd  = (ir_r[10:8] == `MICT_UN_RRC) || (ir_r[10:8] == `MICT_UN_RLC);
                ex_c      = ex_wide[8];
            end
            `MICT_OP_BCLR: begin
                ex_res    = opnd_r & ~ex_mask;
                ex_wr_mem = 1'b1;
            end
            `MICT_OP_BSET: begin
                ex_res    = opnd_r | ex_mask;
                ex_wr_mem = 1'b1;
            end
            `MICT_OP_SKB0: ex_skip = ((opnd_r & ex_mask) == 8'h00);
            `MICT_OP_SKB1: ex_skip = ((opnd_r & ex_mask) != 8'h00);
            `MICT_OP_SKIP: begin
                case (ir_r[9:8])
                    `MICT_SK_SIZ: ex_res = opnd_r + 8'h01;
                    `MICT_SK_SDZ: ex_res = opnd_r - 8'h01;
                    default:      ex_res = opnd_r;
                endcase
                if (ir_r[9:8] == `MICT_SK_SNZ) begin
                    ex_skip = (ex_res != 8'h00);
                end else begin
                    ex_skip = (ex_res == 8'h00);
                end
                ex_wr_acc = ir_r[10];
                ex_wr_mem = !ir_r[10] && (ir_r[9:8] >= `MICT_SK_SIZ);
            end
            `MICT_OP_TABLE: ex_table = 1'b1;
            `MICT_OP_JUMP: begin
                ex_jump   = 1'b1;
                ex_target = ir_r[11:0];
            end
            `MICT_OP_CALL: begin
                ex_jump   = 1'b1;
                ex_push   = 1'b1;
                ex_target = ir_r[11:0];
            end
            default: ex_res = opnd_r;
        endcase
    end

    // ************************************************************
    // wake pin synchroniser
    // ************************************************************
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wake_s1_r <= 1'b0;
            wake_s2_r <= 1'b0;
        end else begin
            wake_s1_r <= wake_i;
            wake_s2_r <= wake_s1_r;
        end
    end

    // ************************************************************
    // sequencer
    // ************************************************************
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            phase_r      <= 2'h0;
            state_r      <= ST_RUN;
            pc_r         <= `MICT_PC_RST;
            pmem_addr_r  <= `MICT_PC_RST;
            ir_r         <= 16'h0000;
            opnd_r       <= 8'h00;
            acc_r        <= `MICT_ACC_RST;
            zero_r       <= 1'b0;
            carry_r      <= 1'b0;
            gie_r        <= 1'b0;
            tblh_r       <= 8'h00;
            dmem_addr_r  <= 10'h000;
            dmem_wdata_r <= 8'h00;
            dmem_we_r    <= 1'b0;
            sp_r         <= 3'h0;
            for (i = 0; i < 8; i = i + 1) begin
                stack_r[i] <= `MICT_PC_RST;
            end
        end else begin
            phase_r   <= phase_r + `MICT_PH_STEP;
            dmem_we_r <= 1'b0;
            case (state_r)
                ST_RUN: begin
                    if (phase_r == `MICT_PH_DECODE) begin
                        ir_r        <= pmem_data_i;
                        pc_r        <= pc_inc;
                        dmem_addr_r <= {`MICT_SECTOR0, pmem_data_i[7:0]};
                    end
                    if (phase_r == `MICT_PH_READ) begin
                        if (ir_r[7:0] == `MICT_PCL_ADDR) begin
                            opnd_r <= pc_r[7:0];
                        end else begin
                            opnd_r <= dmem_rdata_i;
                        end
                    end
                    if (phase_r == `MICT_PH_LAST) begin
                        if (ex_wr_acc) begin
                            acc_r <= ex_res;
                        end
                        if (ex_z_upd) begin
                            zero_r <= (ex_res == 8'h00);
                        end
                        if (ex_c_upd) begin
                            carry_r <= ex_c;
                        end
                        if (ex_wr_mem && !pcl_hit) begin
                            dmem_we_r    <= 1'b1;
                            dmem_wdata_r <= ex_res;
                        end
                        if (ex_gie_set) begin
                            gie_r <= 1'b1;
                        end
                        if (ex_push) begin
                            stack_r[sp_r] <= pc_r;
                            sp_r          <= sp_r + `MICT_SP_STEP;
                        end
                        if (ex_pop) begin
                            sp_r <= sp_top;
                        end
                        if (ex_halt) begin
                            state_r     <= ST_HALT;
                            pmem_addr_r <= pc_r;
                        end else if (ex_table) begin
                            state_r     <= ST_TABLE;
                            pmem_addr_r <= {ir_r[11:8], acc_r};
                        end else if (ex_jump) begin
                            state_r     <= ST_FLUSH;
                            pc_r        <= ex_target;
                            pmem_addr_r <= ex_target;
                        end else if (pcl_hit) begin
                            state_r     <= ST_FLUSH;
                            pc_r        <= {pc_r[11:8], ex_res};
                            pmem_addr_r <= {pc_r[11:8], ex_res};
                        end else if (ex_skip) begin
                            state_r     <= ST_FLUSH;
                            pc_r        <= pc_inc;
                            pmem_addr_r <= pc_inc;
                        end else begin
                            pmem_addr_r <= pc_r;
                        end
                    end
                end
                ST_TABLE: begin
                    if (phase_r == `MICT_PH_LAST) begin
                        tblh_r <= pmem_data_i[15:8];
                        if (ir_r[7:0] == `MICT_PCL_ADDR) begin
                            state_r     <= ST_FLUSH;
                            pc_r        <= {pc_r[11:8], pmem_data_i[7:0]};
                            pmem_addr_r <= {pc_r[11:8], pmem_data_i[7:0]};
                        end else begin
                            dmem_we_r    <= 1'b1;
                            dmem_wdata_r <= pmem_data_i[7:0];
                            state_r      <= ST_RUN;
                            pmem_addr_r  <= pc_r;
                        end
                    end
                end
                ST_FLUSH: begin
                    // fetched word dropped
                    if (phase_r == `MICT_PH_LAST) begin
                        state_r     <= ST_RUN;
                        pmem_addr_r <= pc_r;
                    end
                end
                default: begin
                    if ((phase_r == `MICT_PH_LAST) && wake_s2_r) begin
                        state_r     <= ST_RUN;
                        pmem_addr_r <= pc_r;
                    end
                end
            endcase
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign pmem_addr_o               = pmem_addr_r;
    assign dmem_addr_o               = dmem_addr_r;
    assign dmem_wdata_o              = dmem_wdata_r;
    assign dmem_we_o                 = dmem_we_r;
    assign acc_o                     = acc_r;
    assign tblh_o                    = tblh_r;
    assign zero_o                    = zero_r;
    assign carry_o                   = carry_r;
    assign global_interrupt_enable_o = gie_r;
    assign halt_o                    = (state_r == ST_HALT);
    assign icyc_end_o                = (phase_r == `MICT_PH_LAST);

endmodule // mict_core
`default_nettype wire

// ### src/mict_regs.vh
// constants for the instruction sequencing core
`ifndef MICT_REGS_VH
`define MICT_REGS_VH

// ************************************************************
// timing: one instruction cycle is four system clocks
// ************************************************************
`define MICT_PH_STEP    2'h1
`define MICT_PH_DECODE  2'h1
`define MICT_PH_READ    2'h2
`define MICT_PH_LAST    2'h3

// ************************************************************
// reset values and fixed addresses
// ************************************************************
`define MICT_PC_RST     12'h000
`define MICT_ACC_RST    8'h00
`define MICT_PCL_ADDR   8'h02
`define MICT_SECTOR0    2'h0
`define MICT_SP_STEP    3'h1
`define MICT_PC_STEP    12'h001

// ************************************************************
// major opcodes, bits 15:12
// ************************************************************
`define MICT_OP_MISC    4'h0
`define MICT_OP_ALU_A   4'h1
`define MICT_OP_ALU_M   4'h2
`define MICT_OP_ALU_I   4'h3
`define MICT_OP_UN_A    4'h4
`define MICT_OP_UN_M    4'h5
`define MICT_OP_BCLR    4'h6
`define MICT_OP_BSET    4'h7
`define MICT_OP_SKB0    4'h8
`define MICT_OP_SKB1    4'h9
`define MICT_OP_SKIP    4'ha
`define MICT_OP_TABLE   4'hb
`define MICT_OP_JUMP    4'hc
`define MICT_OP_CALL    4'hd

// ************************************************************
// sub functions
// ************************************************************
`define MICT_MISC_NOP   4'h0
`define MICT_MISC_HALT  4'h1
`define MICT_MISC_RET   4'h2
`define MICT_MISC_INTERRUPT_RETURN  4'h3
`define MICT_MISC_RETA  4'h4
`define MICT_ALU_ADD    3'h0
`define MICT_ALU_ADC    3'h1
`define MICT_ALU_SUB    3'h2
`define MICT_ALU_SBC    3'h3
`define MICT_ALU_AND    3'h4
`define MICT_ALU_OR     3'h5
`define MICT_ALU_XOR    3'h6
`define MICT_ALU_MOV    3'h7
`define MICT_UN_CPL     3'h0
`define MICT_UN_INC     3'h1
`define MICT_UN_DEC     3'h2
`define MICT_UN_RR      3'h3
`define MICT_UN_RL      3'h4
`define MICT_UN_RRC     3'h5
`define MICT_UN_RLC     3'h6
`define MICT_UN_SWAP    3'h7
`define MICT_SK_SZ      2'h0
`define MICT_SK_SNZ     2'h1
`define MICT_SK_SIZ     2'h2
`define MICT_SK_SDZ     2'h3

`endif
